// ---- mem_select_pkg.sv ----
// Shared constants and types for the memory select and sector protect block.
// Assumes a 50 MHz core clock and an 8-bit host bus.
package mem_select_pkg;

  // Timing
  localparam int CLK_FREQ_HZ = 50_000_000;
  localparam int RECOVERY_TIME_US = 25;
  localparam int RECOVERY_CYCLES = (RECOVERY_TIME_US * (CLK_FREQ_HZ / 1_000_000));
  localparam int RECOV_W = $clog2(RECOVERY_CYCLES);

  // Register space offsets and reset command data
  localparam logic [7:0] OFFS_MAIN_PROT = 8'hC0;
  localparam logic [7:0] OFFS_BOOT_PROT = 8'hC2;
  localparam logic [7:0] OFFS_MAP = 8'hC4;
  localparam logic [7:0] RESET_CMD_DATA = 8'hF0;

  // Unlock prefix
  localparam logic [11:0] UNLOCK1_ADDR = 12'hAAA;
  localparam logic [7:0] UNLOCK1_DATA = 8'hAA;
  localparam logic [11:0] UNLOCK2_ADDR = 12'h554;
  localparam logic [7:0] UNLOCK2_DATA = 8'h55;

  // Space mapping register fields
  localparam int MAP_PARALLEL_IO_ENABLE = 7;
  localparam int MAP_RD_MAIN = 4;
  localparam int MAP_RD_BOOT = 3;
  localparam int MAP_FETCH_MAIN = 2;
  localparam int MAP_FETCH_BOOT = 1;
  localparam int MAP_FETCH_SRAM = 0;
  localparam logic [7:0] MAP_WRITABLE = 8'h9F;
  localparam logic [7:0] MAP_RESET = 8'h00;
  localparam int SECURITY_BIT = 7;

  typedef struct packed {
    logic [7:0] main;
    logic [3:0] boot;
    logic sram;
    logic regs;
  } memSelect_t;

  typedef struct packed {
    logic security;
    logic [3:0] boot;
    logic [7:0] main;
  } protImage_t;

  localparam protImage_t PROT_RESET = 13'h0000;

  typedef enum logic [1:0] {KIND_PROGRAM, KIND_BULK, KIND_SECTOR} opKind_t;
  typedef enum logic [2:0] {
    OP_IDLE, OP_PROGRAM, OP_BULK, OP_SECTOR, OP_RECOVER
  } flashOp_t;
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_FIRST, SEQ_SECOND} cmdSeq_t;

  // Strobe permission from the mapping bits; writes are never gated
  function automatic logic strobePermit(input logic fetch, input logic rd,
                                        input logic fetchBit,
                                        input logic rdBit);
    if (fetch) return fetchBit;
    if (rd) return rdBit;
    return 1'b1;
  endfunction

  function automatic logic sectorHit(input logic [7:0] main,
                                     input logic [3:0] boot,
                                     input protImage_t prot);
    return (|(main & prot.main)) || (|(boot & prot.boot));
  endfunction

endpackage

// ---- select_router.sv ----
// Priority and strobe permission among the decoder's memory selects.
// Assumes selects arrive already decoded and synchronous to the clock.
`timescale 1ns/1ns
`default_nettype none
module select_router
  import mem_select_pkg::*;
(
  input wire memSelect_t rawSel,
  input wire logic busRd,
  input wire logic codeFetch,
  input wire logic [7:0] mapping,
  output memSelect_t routed
);

  logic upperLevel;
  logic bootAny;
  logic permitMain;
  logic permitBoot;

  always_comb begin
    upperLevel = rawSel.sram || rawSel.regs;
    bootAny = |rawSel.boot;
    permitMain = strobePermit(codeFetch, busRd, mapping[MAP_FETCH_MAIN],
                              mapping[MAP_RD_MAIN]);
    permitBoot = strobePermit(codeFetch, busRd, mapping[MAP_FETCH_BOOT],
                              mapping[MAP_RD_BOOT]);
    routed.regs = rawSel.regs;
    // Data reads always reach SRAM; only fetches are gated
    routed.sram = rawSel.sram
      && (!codeFetch || mapping[MAP_FETCH_SRAM]);
    // Priority follows raw selects, so a refused upper level still shadows
    routed.boot = upperLevel ? 4'h0
      : (rawSel.boot & {4{permitBoot}});
    routed.main = (upperLevel || bootAny) ? 8'h00
      : (rawSel.main & {8{permitMain}});
  end

endmodule // select_router
`default_nettype wire

// ---- flash_cmd_sequencer.sv ----
// Flash command write sequencer: reset command and unlock prefix.
// Assumes flashWr is a one-cycle write aimed at a flash sector.
`timescale 1ns/1ns
`default_nettype none
module flash_cmd_sequencer
  import mem_select_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic clkEn,
  input wire logic flashWr,
  input wire logic [11:0] cmdAddr,
  input wire logic [7:0] cmdData,
  output logic resetCmd,
  output logic passWrite
);

  cmdSeq_t seqState;
  logic firstHit;
  logic secondHit;

  always_comb begin
    firstHit = (cmdAddr == UNLOCK1_ADDR) && (cmdData == UNLOCK1_DATA);
    secondHit = (cmdAddr == UNLOCK2_ADDR) && (cmdData == UNLOCK2_DATA);
    // Reset needs no prefix, but a prefix before it is harmless
    resetCmd = flashWr && (cmdData == RESET_CMD_DATA);
    passWrite = flashWr && !resetCmd
      && !((seqState == SEQ_IDLE) && firstHit)
      && !((seqState == SEQ_FIRST) && secondHit);
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      seqState <= SEQ_IDLE;
    end else if (clkEn && flashWr) begin
      case (seqState)
        SEQ_IDLE: seqState <= (firstHit && !resetCmd) ? SEQ_FIRST : SEQ_IDLE;
        SEQ_FIRST: seqState <= (secondHit && !resetCmd) ? SEQ_SECOND
                                                        : SEQ_IDLE;
        SEQ_SECOND: seqState <= SEQ_IDLE;
        default: seqState <= SEQ_IDLE;
      endcase
    end
  end

endmodule // flash_cmd_sequencer
`default_nettype wire

// ---- memory_select_and_sector_protect.sv ----
// Memory select, sector protection, space mapping and flash reset control.
// Assumes host bus inputs and decoder selects are synchronous to core_clk,
// and that a flash engine reports opDone / opError for granted operations.
`timescale 1ns/1ns
`default_nettype none
module memory_select_and_sector_protect
  import mem_select_pkg::*;
#(
  parameter logic [7:0] MAIN_PROT_OFFSET = OFFS_MAIN_PROT,
  parameter logic [7:0] BOOT_PROT_OFFSET = OFFS_BOOT_PROT,
  parameter logic [7:0] MAP_OFFSET = OFFS_MAP
)(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic clkEn,
  input wire logic [15:0] busAddr,
  input wire logic [7:0] busWrData,
  input wire logic busWr,
  input wire logic busRd,
  input wire logic codeFetch,
  input wire memSelect_t decoderSelect,
  input wire logic progReq,
  input wire opKind_t progKind,
  input wire logic opDone,
  input wire logic opError,
  input wire logic resetPin,
  input wire logic [7:0] arrayRdData,
  input wire logic protLoad,
  input wire protImage_t protImage,
  input wire logic [7:0] cfgMapping,
  output memSelect_t memEnable,
  output logic [7:0] regRdData,
  output logic regRdValid,
  output logic [7:0] flashRdData,
  output logic flashReadMode,
  output logic flashAbort,
  output logic errorStatusBit,
  output logic progEraseGo,
  output opKind_t progEraseKind,
  output logic flashCmdWrite,
  output logic [7:0] flashCmdData,
  output logic parallelIoEnable
);

  ////////////////////////////////////////////////////////////////////////////
  // Selects and command decode

  memSelect_t routed;
  protImage_t prot;
  logic [7:0] mapping;
  logic cfgLoaded;
  logic flashWr;
  logic resetCmd;
  logic passWrite;
  logic regWrite;
  logic regRead;
  logic [7:0] regOffset;
  logic targetAny;
  logic targetProtected;

  select_router u_router (
    .rawSel(decoderSelect),
    .busRd(busRd),
    .codeFetch(codeFetch),
    .mapping(mapping),
    .routed(routed)
  );

  assign flashWr = busWr && ((|routed.main) || (|routed.boot));
  assign regWrite = busWr && decoderSelect.regs;
  assign regRead = busRd && decoderSelect.regs;
  assign regOffset = busAddr[7:0];
  assign targetAny = (|routed.main) || (|routed.boot);
  assign targetProtected = sectorHit(routed.main, routed.boot, prot);

  flash_cmd_sequencer u_seq (
    .core_clk(core_clk),
    .nrst(nrst),
    .clkEn(clkEn),
    .flashWr(flashWr),
    .cmdAddr(busAddr[11:0]),
    .cmdData(busWrData),
    .resetCmd(resetCmd),
    .passWrite(passWrite)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Protection image, loaded only from the test port

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      prot <= PROT_RESET;
    end else if (clkEn && protLoad) begin
      prot <= protImage;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Space mapping register

  // Configuration value is caught after reset release, never under reset
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mapping <= MAP_RESET;
      cfgLoaded <= 1'b0;
    end else if (clkEn) begin
      cfgLoaded <= 1'b1;
      if (!cfgLoaded) begin
        mapping <= cfgMapping & MAP_WRITABLE;
      end else if (regWrite && (regOffset == MAP_OFFSET)) begin
        mapping <= busWrData & MAP_WRITABLE;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      parallelIoEnable <= 1'b0;
    end else if (clkEn) begin
      parallelIoEnable <= mapping[MAP_PARALLEL_IO_ENABLE];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register reads; protection registers ignore host writes

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      regRdData <= 8'h00;
      regRdValid <= 1'b0;
    end else if (clkEn) begin
      regRdValid <= regRead;
      if (regRead) begin
        if (regOffset == MAIN_PROT_OFFSET) begin
          regRdData <= prot.main;
        end else if (regOffset == BOOT_PROT_OFFSET) begin
          regRdData <= {prot.security, 3'h0, prot.boot};
        end else if (regOffset == MAP_OFFSET) begin
          regRdData <= mapping;
        end else begin
          regRdData <= 8'h00;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Memory enables and flash read data

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      memEnable <= '0;
      flashRdData <= 8'h00;
    end else if (clkEn) begin
      memEnable <= routed;
      // Protected sectors were never written, so reads return stored data
      if ((busRd || codeFetch) && targetAny) begin
        flashRdData <= arrayRdData;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      flashCmdWrite <= 1'b0;
      flashCmdData <= 8'h00;
    end else if (clkEn) begin
      flashCmdWrite <= passWrite;
      if (passWrite) begin
        flashCmdData <= busWrData;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flash operation state, reset command and reset pin

  flashOp_t opState;
  flashOp_t next_opState;
  logic next_err;
  logic goGrant;
  logic abortNow;
  logic loadRecov;
  logic [RECOV_W-1:0] recovCount;

  always_comb begin
    next_opState = opState;
    next_err = errorStatusBit;
    goGrant = 1'b0;
    abortNow = 1'b0;
    loadRecov = 1'b0;
    if (resetPin) begin
      next_err = 1'b0;
      if (opState inside {OP_PROGRAM, OP_BULK, OP_SECTOR}) begin
        abortNow = 1'b1;
        loadRecov = 1'b1;
        next_opState = OP_RECOVER;
      end else if (opState != OP_RECOVER) begin
        next_opState = OP_IDLE;
      end
    end else begin
      case (opState)
        OP_IDLE: begin
          if (resetCmd) begin
            if (errorStatusBit) begin
              loadRecov = 1'b1;
              next_opState = OP_RECOVER;
            end
          end else if (progReq && targetAny && !targetProtected
                       && !errorStatusBit) begin
            goGrant = 1'b1;
            case (progKind)
              KIND_PROGRAM: next_opState = OP_PROGRAM;
              KIND_BULK: next_opState = OP_BULK;
              KIND_SECTOR: next_opState = OP_SECTOR;
              default: next_opState = OP_IDLE;
            endcase
          end
        end
        OP_PROGRAM, OP_BULK: begin
          // Reset command has no effect here
          if (opError) begin
            next_err = 1'b1;
            next_opState = OP_IDLE;
          end else if (opDone) begin
            next_opState = OP_IDLE;
          end
        end
        OP_SECTOR: begin
          if (resetCmd) begin
            abortNow = 1'b1;
            loadRecov = 1'b1;
            next_opState = OP_RECOVER;
          end else if (opError) begin
            next_err = 1'b1;
            next_opState = OP_IDLE;
          end else if (opDone) begin
            next_opState = OP_IDLE;
          end
        end
        OP_RECOVER: begin
          if (recovCount == '0) begin
            next_opState = OP_IDLE;
            next_err = 1'b0;
          end
        end
        default: next_opState = OP_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      opState <= OP_IDLE;
      errorStatusBit <= 1'b0;
      flashReadMode <= 1'b1;
    end else if (clkEn) begin
      opState <= next_opState;
      errorStatusBit <= next_err;
      flashReadMode <= (next_opState == OP_IDLE) && !next_err;
    end
  end

  // Recovery lasts the documented worst case, 25 us, or until resetPin falls if that is later
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      recovCount <= '0;
    end else if (clkEn) begin
      if (loadRecov) begin
        recovCount <= RECOV_W'(RECOVERY_CYCLES - 1);
      end else if ((opState == OP_RECOVER) && (recovCount != '0)) begin
        recovCount <= recovCount - 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      progEraseGo <= 1'b0;
      progEraseKind <= KIND_PROGRAM;
      flashAbort <= 1'b0;
    end else if (clkEn) begin
      progEraseGo <= goGrant;
      flashAbort <= abortNow;
      if (goGrant) begin
        progEraseKind <= progKind;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  // Recovery is too long for a delay range, so a counter bounds it
  logic [11:0] abortWait;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      abortWait <= 12'h000;
    end else if (clkEn) begin
      if (flashAbort) begin
        abortWait <= 12'h001;
      end else if (flashReadMode) begin
        abortWait <= 12'h000;
      end else if ((abortWait != 12'h000) && !resetPin) begin
        abortWait <= abortWait + 12'h001;
      end
    end
  end

  sequence s_sectorResetCmd;
    clkEn && resetCmd && !resetPin && (opState == OP_SECTOR);
  endsequence

  sequence s_abortThenRead;
    flashAbort && (opState == OP_RECOVER);
  endsequence

  property p_protectBlocks;
    clkEn && progReq && sectorHit(routed.main, routed.boot, prot)
      |=> !progEraseGo;
  endproperty
  a_protectBlocks: assert property (p_protectBlocks)
    else $error("program or erase granted on a protected sector");

  property p_protReadOnly;
    clkEn && !protLoad |=> $stable(prot);
  endproperty
  a_protReadOnly: assert property (p_protReadOnly)
    else $error("protection bits changed without the test port");

  property p_mainStatus;
    clkEn && regRead && (regOffset == MAIN_PROT_OFFSET)
      |=> regRdValid && (regRdData == $past(prot.main));
  endproperty
  a_mainStatus: assert property (p_mainStatus)
    else $error("main protection status read wrong");

  property p_bootStatus;
    clkEn && regRead && (regOffset == BOOT_PROT_OFFSET)
      |=> (regRdData[3:0] == $past(prot.boot)) && (regRdData[6:4] == 3'h0)
        && (regRdData[SECURITY_BIT] == $past(prot.security));
  endproperty
  a_bootStatus: assert property (p_bootStatus)
    else $error("secondary protection status read wrong");

  property p_resetImmediate;
    clkEn && resetCmd && !resetPin && (opState == OP_IDLE) && !errorStatusBit
      |=> flashReadMode;
  endproperty
  a_resetImmediate: assert property (p_resetImmediate)
    else $error("reset command did not give read mode at once");

  property p_resetIgnored;
    clkEn && resetCmd && !resetPin && !opDone && !opError
      && (opState inside {OP_PROGRAM, OP_BULK})
      |=> (opState == $past(opState)) && !flashAbort;
  endproperty
  a_resetIgnored: assert property (p_resetIgnored)
    else $error("reset command disturbed program or bulk erase");

  property p_sectorAbort;
    s_sectorResetCmd |=> s_abortThenRead;
  endproperty
  a_sectorAbort: assert property (p_sectorAbort)
    else $error("sector erase not aborted into recovery");

  property p_recoverBound;
    abortWait <= 12'(RECOVERY_CYCLES);
  endproperty
  a_recoverBound: assert property (p_recoverBound)
    else $error("read mode not back within the recovery time");

  property p_pinAbort;
    clkEn && resetPin && (opState inside {OP_PROGRAM, OP_BULK, OP_SECTOR})
      |=> flashAbort && (opState == OP_RECOVER);
  endproperty
  a_pinAbort: assert property (p_pinAbort)
    else $error("reset pin did not abort the running operation");

  property p_sramGate;
    clkEn && !decoderSelect.sram |=> !memEnable.sram;
  endproperty
  a_sramGate: assert property (p_sramGate)
    else $error("SRAM enabled without its select");

  property p_bootPriority;
    clkEn && (|decoderSelect.boot) && (|decoderSelect.main)
      |=> memEnable.main == 8'h00;
  endproperty
  a_bootPriority: assert property (p_bootPriority)
    else $error("main sector enabled over a secondary sector");

  property p_upperPriority;
    clkEn && (decoderSelect.sram || decoderSelect.regs)
      |=> (memEnable.main == 8'h00) && (memEnable.boot == 4'h0);
  endproperty
  a_upperPriority: assert property (p_upperPriority)
    else $error("flash enabled over SRAM or register space");

  property p_mapWrite;
    clkEn && cfgLoaded && regWrite && (regOffset == MAP_OFFSET)
      |=> mapping == ($past(busWrData) & MAP_WRITABLE);
  endproperty
  a_mapWrite: assert property (p_mapWrite)
    else $error("mapping register write not taken");

  property p_errorBit;
    clkEn && opError && !resetPin && (opState inside {OP_PROGRAM, OP_BULK})
      |=> errorStatusBit && !flashReadMode;
  endproperty
  a_errorBit: assert property (p_errorBit)
    else $error("error status bit not raised on failure");

  property p_fetchPermit;
    clkEn && codeFetch && !mapping[MAP_FETCH_SRAM] |=> !memEnable.sram;
  endproperty
  a_fetchPermit: assert property (p_fetchPermit)
    else $error("code fetch reached SRAM without permission");

endmodule // memory_select_and_sector_protect
`default_nettype wire

// ---- flash_engine_model.sv ----
// Flash engine stand-in: answers granted program and erase operations.
// Assumes go and abort arrive as one-cycle pulses from the block.
`timescale 1ns/1ns
`default_nettype none
module flash_engine_model (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic go,
  input wire logic abort,
  input wire logic slow,
  input wire logic fail,
  output logic opDone,
  output logic opError
);
  logic [11:0] left;
  // Slow ops outlast recovery, so aborts always land mid-operation
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      left <= '0;
      opDone <= 1'b0;
      opError <= 1'b0;
    end else begin
      opDone <= (left == 12'h001) && !fail;
      opError <= (left == 12'h001) && fail;
      if (go) left <= slow ? 12'hFFF : 12'h008;
      else if (abort) left <= '0;
      else if (left != '0) left <= left - 12'h001;
    end
  end
endmodule // flash_engine_model
`default_nettype wire

// ---- tb_top.sv ----
// Self-checking bench for the memory select and sector protect block.
// Assumes the package, the block and the engine stand-in compile first.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import mem_select_pkg::*;
  logic core_clk, nrst, busWr, busRd, codeFetch, progReq, resetPin;
  logic protLoad, slow, fail, opDone, opError, regRdValid, flashAbort;
  logic flashReadMode, errorStatusBit, progEraseGo, flashCmdWrite, pio;
  logic [15:0] busAddr;
  logic [7:0] busWrData, arrayRdData, cfgMapping, regRdData, flashRdData;
  logic [7:0] flashCmdData;
  memSelect_t decoderSelect, memEnable;
  opKind_t progKind, progEraseKind;
  protImage_t protImage;
  logic [7:0] expQ[$];
  int n_fail, samples_checked, ab, rm;
  localparam memSelect_t RG = 14'h0001;
  localparam memSelect_t SR = 14'h0002;
  localparam memSelect_t B0 = 14'h0004;
  localparam memSelect_t M0 = 14'h0040;
  localparam memSelect_t M1 = 14'h0080;
  localparam memSelect_t M2 = 14'h0100;
  // One sector per select, no overlap on one level

  memory_select_and_sector_protect memory_select_and_sector_protect_i (
    .core_clk(core_clk), .nrst(nrst), .clkEn(1'b1), .busAddr(busAddr),
    .busWrData(busWrData), .busWr(busWr), .busRd(busRd),
    .codeFetch(codeFetch), .decoderSelect(decoderSelect),
    .progReq(progReq), .progKind(progKind), .opDone(opDone),
    .opError(opError), .resetPin(resetPin), .arrayRdData(arrayRdData),
    .protLoad(protLoad), .protImage(protImage), .cfgMapping(cfgMapping),
    .memEnable(memEnable), .regRdData(regRdData), .regRdValid(regRdValid),
    .flashRdData(flashRdData), .flashReadMode(flashReadMode),
    .flashAbort(flashAbort), .errorStatusBit(errorStatusBit),
    .progEraseGo(progEraseGo), .progEraseKind(progEraseKind),
    .flashCmdWrite(flashCmdWrite), .flashCmdData(flashCmdData),
    .parallelIoEnable(pio));
  flash_engine_model flash_engine_model_i (.core_clk(core_clk),
    .nrst(nrst), .go(progEraseGo), .abort(flashAbort), .slow(slow),
    .fail(fail), .opDone(opDone), .opError(opError));

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Register answers arrive one cycle later; oldest note pairs first
  always @(negedge core_clk) begin
    if (regRdValid === 1'b1) begin
      check("regRdData", regRdData, expQ.size() ? expQ.pop_front() : 8'hXX);
    end
  end

  task automatic bus(logic [15:0] a, logic [7:0] d, logic wr, memSelect_t s);
    @(negedge core_clk);
    busAddr = a;
    busWrData = d;
    busWr = wr;
    busRd = !wr;
    decoderSelect = s;
    @(negedge core_clk);
    busWr = 1'b0;
    busRd = 1'b0;
    decoderSelect = '0;
  endtask

  task automatic rd(logic [7:0] a, logic [7:0] exp);
    expQ.push_back(exp);
    bus({8'h00, a}, 8'h00, 1'b0, RG);
  endtask

  task automatic route(memSelect_t s, logic fet, memSelect_t exp);
    @(negedge core_clk);
    decoderSelect = s;
    busRd = !fet;
    codeFetch = fet;
    @(negedge core_clk);
    check("memEnable", memEnable, exp);
    decoderSelect = '0;
    busRd = 1'b0;
    codeFetch = 1'b0;
  endtask

  task automatic prog(memSelect_t s, opKind_t k, logic expGo);
    @(negedge core_clk);
    decoderSelect = s;
    progReq = 1'b1;
    progKind = k;
    @(negedge core_clk);
    progReq = 1'b0;
    decoderSelect = '0;
    check("progEraseGo", progEraseGo, expGo);
    if (expGo) check("progEraseKind", progEraseKind, k);
  endtask

  task automatic run(int cyc);
    ab = 0;
    rm = 0;
    for (int n = 1; n <= cyc; n++) begin
      @(negedge core_clk);
      if (flashAbort === 1'b1 && ab == 0) ab = n;
      if (flashReadMode === 1'b1 && rm == 0) rm = n;
    end
  endtask

  initial begin
    repeat (12000) @(posedge core_clk);
    n_fail++;
    report_and_stop();
  end

  initial begin
    void'($urandom(55222));
    {nrst, busWr, busRd, codeFetch, progReq, resetPin, protLoad} = '0;
    {slow, fail, busAddr, busWrData, decoderSelect} = '0;
    progKind = KIND_PROGRAM;
    cfgMapping = 8'($urandom());
    arrayRdData = 8'($urandom());
    protImage = 13'($urandom());
    protImage.main[1] = 1'b1;
    protImage.main[2] = 1'b0;
    repeat (20) @(negedge core_clk);
    nrst = 1'b1;
    repeat (2) @(negedge core_clk);
    rd(8'hC4, cfgMapping & 8'h9F);
    protLoad = 1'b1;
    @(negedge core_clk);
    protLoad = 1'b0;
    bus(16'h00C0, 8'hFF, 1'b1, RG);
    rd(8'hC0, protImage.main);
    rd(8'hC2, {protImage.security, 3'b000, protImage.boot});
    rd(8'h10, 8'h00);
    bus(16'h00C4, 8'hFF, 1'b1, RG);
    rd(8'hC4, 8'h9F);
    check("pio", pio, 1'b1);
    $display("test registers done");
    route(M0 | B0, 1'b0, B0);
    route(M0 | SR, 1'b0, SR);
    route(M1, 1'b0, M1);
    check("flashRdData", flashRdData, arrayRdData);
    bus(16'h00C4, 8'h0C, 1'b1, RG);
    route(M0, 1'b0, '0);
    route(M0, 1'b1, M0);
    route(B0, 1'b0, B0);
    $display("test routing done");
    slow = 1'b1;
    prog(M1, KIND_SECTOR, 1'b0);
    prog(M2, KIND_BULK, 1'b1);
    bus(16'h0000, RESET_CMD_DATA, 1'b1, M2);
    run(20);
    check("abort", 16'(ab), 16'd0);
    resetPin = 1'b1;
    run(1300);
    check("pin abort", 16'(ab), 16'd1);
    resetPin = 1'b0;
    @(negedge core_clk);
    check("readMode", flashReadMode, 1'b1);
    prog(M2, KIND_SECTOR, 1'b1);
    bus(16'h0000, RESET_CMD_DATA, 1'b1, M2);
    check("erase abort", flashAbort, 1'b1);
    run(1300);
    check("abort once", 16'(ab), 16'd0);
    check("erase recovery", 16'(rm), 16'd1250);
    $display("test abort done");
    {slow, fail} = 2'b01;
    prog(M2, KIND_PROGRAM, 1'b1);
    run(12);
    check("error bit", errorStatusBit, 1'b1);
    bus(16'h0AAA, 8'hAA, 1'b1, M2);
    bus(16'h0554, 8'h55, 1'b1, M2);
    bus(16'h0000, RESET_CMD_DATA, 1'b1, M2);
    run(1300);
    check("error recovery", 16'(rm), 16'd1250);
    check("error bit", errorStatusBit, 1'b0);
    bus(16'h0000, 8'h30, 1'b1, M2);
    check("cmdWrite", {flashCmdWrite, flashCmdData}, 9'h130);
    $display("test reset command done");
    report_and_stop();
  end
endmodule // tb_top
`default_nettype wire
